// ===== pkg/iexu_pkg.sv
/*
  Constants, types and the instruction classes used by the exception unit.
  Assumes a 32-bit core with 16-bit opcodes and a 32-bit data bus.
*/
package iexu_pkg;

  localparam int unsigned IEXU_AW = 32;
  localparam int unsigned IEXU_VW = 8;
  localparam logic [31:0] IEXU_WORD_BYTES = 32'h0000_0004;
  localparam logic [1:0] IEXU_ALIGN_MASK = 2'h3;
  localparam logic [7:0] IEXU_VEC_ILL_GEN = 8'h04;
  localparam logic [7:0] IEXU_VEC_ILL_SLOT = 8'h06;
  localparam logic [7:0] IEXU_VEC_ADDR_ERR = 8'h09;

  typedef enum logic [3:0] {
    IEXU_CLS_NONE = 4'h0,
    IEXU_CLS_DELAYED = 4'h1,
    IEXU_CLS_PC_PLAIN = 4'h2,
    IEXU_CLS_TRAP = 4'h3,
    IEXU_CLS_IRQ_DIS = 4'h4,
    IEXU_CLS_UNDEF = 4'h5
  } iexu_cls_t;

  typedef enum logic [4:0] {
    IEXU_ST_IDLE = 5'b00001,
    IEXU_ST_PUSH_SR = 5'b00010,
    IEXU_ST_PUSH_PC = 5'b00100,
    IEXU_ST_VEC = 5'b01000,
    IEXU_ST_JUMP = 5'b10000
  } iexu_st_t;

  // Classifies a 16-bit opcode into the groups the sequencer cares about.
  function automatic iexu_cls_t iexu_classify(input logic [15:0] op);
    iexu_cls_t c;
    c = IEXU_CLS_NONE;
    unique casez (op)
      16'h4?2b, 16'h4?0b, 16'h0?23, 16'h0?03, 16'h000b, 16'h002b,
      16'ha???, 16'hb???, 16'h8f??, 16'h8d??: c = IEXU_CLS_DELAYED;
      16'h89??, 16'h8b??: c = IEXU_CLS_PC_PLAIN;
      16'hc3??: c = IEXU_CLS_TRAP;
      16'h4??e, 16'h4??7, 16'h0??2, 16'h4??3, 16'h4??a, 16'h4??6,
      16'h0??a, 16'h4??2: c = IEXU_CLS_IRQ_DIS;
      16'hfff?: c = IEXU_CLS_UNDEF;
      default: c = IEXU_CLS_NONE;
    endcase
    return c;
  endfunction

endpackage

// ===== pkg/iexu_bus_if.sv
/*
  Memory bus carrier between the sequencer and its bus port module.
  Assumes one outstanding access at a time.
*/
interface iexu_bus_if;
  import iexu_pkg::*;
  logic req;
  logic wr;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic done;
  logic [31:0] rdata;
  logic misalign;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata, input misalign);
  modport port (input req, input wr, input addr, input wdata, output done, output rdata, output misalign);
endinterface

// ===== hdl/iexu_bus_port.sv
/*
  Bus port: drives one memory access per request and flags misaligned words.
  Assumes the memory answers each request with a one-cycle ack.
*/
module iexu_bus_port
  import iexu_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  iexu_bus_if.port bus,
  output logic o_mem_req,
  output logic o_mem_wr,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata
);
  typedef struct packed {
    logic busy;
    logic [31:0] rdata;
  } iexu_bp_t;
  iexu_bp_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (bus.req && !s_r.busy) begin
      s_nxt.busy = 1'b1;
    end
    if (s_r.busy && i_mem_ack) begin
      s_nxt.busy = 1'b0;
      s_nxt.rdata = i_mem_rdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // A misaligned write is still issued at the unaligned address.
  assign o_mem_req = s_r.busy;
  assign o_mem_wr = bus.wr;
  assign o_mem_addr = bus.addr;
  assign o_mem_wdata = bus.wdata;
  assign bus.done = s_r.busy && i_mem_ack;
  assign bus.rdata = i_mem_rdata;
  assign bus.misalign = (bus.addr[1:0] & IEXU_ALIGN_MASK) != 2'h0;
endmodule

// ===== hdl/iexu_decode.sv
/*
  Decode stage helper: classifies the decoded opcode and tracks slot state.
  Assumes i_dec_valid pulses once per decoded instruction.
*/
module iexu_decode
  import iexu_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_dec_valid,
  input wire logic [15:0] i_dec_op,
  input wire logic i_flush,
  output iexu_cls_t o_cls,
  output logic o_in_slot,
  output logic o_after_dis
);
  typedef struct packed {
    logic in_slot;
    logic after_dis;
  } iexu_dc_t;
  iexu_dc_t s_r, s_nxt;

  assign o_cls = iexu_classify(i_dec_op);

  always_comb begin
    s_nxt = s_r;
    if (i_flush) begin
      s_nxt = '0;
    end else if (i_dec_valid) begin
      s_nxt.in_slot = (o_cls == IEXU_CLS_DELAYED) && !s_r.in_slot;
      s_nxt.after_dis = (o_cls == IEXU_CLS_IRQ_DIS);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_in_slot = s_r.in_slot;
  assign o_after_dis = s_r.after_dis;
endmodule

// ===== hdl/iexu_top.sv
/*
  Instruction exception sequencer: trap, illegal slot, general illegal,
  held address errors and interrupts, stacking and vector fetch.
  Assumes the pipeline holds decode while o_busy is high.
*/
module iexu_top
  import iexu_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_dec_valid,
  input wire logic [15:0] i_dec_op,
  input wire logic [31:0] i_dec_pc,
  input wire logic [31:0] i_branch_target,
  input wire logic [31:0] i_status_word,
  input wire logic [31:0] i_stack_pointer,
  input wire logic [31:0] i_vector_table_base,
  input wire logic i_addr_err,
  input wire logic i_irq_req,
  input wire logic [7:0] i_irq_vec,
  output logic o_mem_req,
  output logic o_mem_wr,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  output logic o_busy,
  output logic o_irq_ack,
  output logic o_pc_load,
  output logic [31:0] o_program_counter,
  output logic [31:0] o_stack_pointer
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    iexu_st_t st;
    logic [31:0] sp;
    logic [31:0] ret_pc;
    logic [31:0] sr;
    logic [7:0] vec;
    logic ae_pend;
    logic irq_pend;
    logic stack_fault;
    logic nested_ae;
    logic pc_load;
    logic irq_ack;
    logic [31:0] pc;
  } iexu_state_t;
  iexu_state_t s_r, s_nxt;

  iexu_bus_if bus ();
  iexu_cls_t cls;
  logic in_slot;
  logic after_dis;
  logic flush;

  iexu_decode u_dec (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_dec_valid(i_dec_valid && s_r.st == IEXU_ST_IDLE),
    .i_dec_op(i_dec_op),
    .i_flush(flush),
    .o_cls(cls),
    .o_in_slot(in_slot),
    .o_after_dis(after_dis)
  );

  iexu_bus_port u_bus (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .bus(bus),
    .o_mem_req(o_mem_req),
    .o_mem_wr(o_mem_wr),
    .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata),
    .i_mem_ack(i_mem_ack),
    .i_mem_rdata(i_mem_rdata)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [7:0] v);
    return base + {22'h0, v, 2'h0};
  endfunction

  logic dec_go;
  assign dec_go = i_dec_valid && (s_r.st == IEXU_ST_IDLE);
  assign flush = s_r.pc_load;

  always_comb begin
    s_nxt = s_r;
    s_nxt.pc_load = 1'b0;
    s_nxt.irq_ack = 1'b0;
    // Events that cannot be taken now are remembered.
    if (i_addr_err) begin
      s_nxt.ae_pend = 1'b1;
    end
    if (i_irq_req) begin
      s_nxt.irq_pend = 1'b1;
    end
    bus.req = 1'b0;
    bus.wr = 1'b0;
    bus.addr = s_r.sp;
    bus.wdata = s_r.sr;
    unique case (s_r.st)
      IEXU_ST_IDLE: begin
        if (dec_go) begin
          s_nxt.sr = i_status_word;
          s_nxt.sp = i_stack_pointer;
          if (in_slot && (cls == IEXU_CLS_UNDEF || cls == IEXU_CLS_DELAYED
                          || cls == IEXU_CLS_PC_PLAIN || cls == IEXU_CLS_TRAP)) begin
            s_nxt.st = IEXU_ST_PUSH_SR;
            s_nxt.ret_pc = i_branch_target;
            s_nxt.vec = IEXU_VEC_ILL_SLOT;
          end else if (in_slot) begin
            s_nxt.st = IEXU_ST_IDLE;
          end else if (s_r.ae_pend || i_addr_err) begin
            s_nxt.st = IEXU_ST_PUSH_SR;
            s_nxt.ae_pend = 1'b0;
            s_nxt.ret_pc = i_dec_pc;
            s_nxt.vec = IEXU_VEC_ADDR_ERR;
          end else if ((s_r.irq_pend || i_irq_req) && !after_dis) begin
            s_nxt.st = IEXU_ST_PUSH_SR;
            s_nxt.irq_pend = 1'b0;
            s_nxt.irq_ack = 1'b1;
            s_nxt.ret_pc = i_dec_pc;
            s_nxt.vec = i_irq_vec;
          end else if (cls == IEXU_CLS_UNDEF) begin
            s_nxt.st = IEXU_ST_PUSH_SR;
            s_nxt.ret_pc = i_dec_pc;
            s_nxt.vec = IEXU_VEC_ILL_GEN;
          end else if (cls == IEXU_CLS_TRAP) begin
            s_nxt.st = IEXU_ST_PUSH_SR;
            s_nxt.ret_pc = i_dec_pc + 32'h0000_0002;
            s_nxt.vec = i_dec_op[7:0];
          end
        end
      end
      IEXU_ST_PUSH_SR: begin
        bus.req = 1'b1;
        bus.wr = 1'b1;
        bus.addr = s_r.sp - IEXU_WORD_BYTES;
        bus.wdata = s_r.sr;
        if (bus.done) begin
          s_nxt.sp = s_r.sp - IEXU_WORD_BYTES;
          if (bus.misalign && !s_r.nested_ae) begin
            s_nxt.stack_fault = 1'b1;
          end
          s_nxt.st = IEXU_ST_PUSH_PC;
        end
      end
      IEXU_ST_PUSH_PC: begin
        bus.req = 1'b1;
        bus.wr = 1'b1;
        bus.addr = s_r.sp - IEXU_WORD_BYTES;
        bus.wdata = s_r.ret_pc;
        if (bus.done) begin
          s_nxt.sp = s_r.sp - IEXU_WORD_BYTES;
          if (bus.misalign && !s_r.nested_ae) begin
            s_nxt.stack_fault = 1'b1;
          end
          s_nxt.st = IEXU_ST_VEC;
        end
      end
      IEXU_ST_VEC: begin
        bus.req = 1'b1;
        bus.addr = vec_addr(i_vector_table_base, s_r.vec);
        if (bus.done) begin
          s_nxt.pc = bus.rdata;
          s_nxt.st = IEXU_ST_JUMP;
        end
      end
      IEXU_ST_JUMP: begin
        // The jump is undelayed: decode restarts at the handler unless a stack fault starts the nested address error entry.
        s_nxt.pc_load = 1'b1;
        s_nxt.st = IEXU_ST_IDLE;
        s_nxt.nested_ae = 1'b0;
        if (s_r.stack_fault) begin
          s_nxt.stack_fault = 1'b0;
          s_nxt.nested_ae = 1'b1;
          // The nested entry stacks the handler address just loaded; read data no longer stands here.
          s_nxt.ret_pc = s_r.pc;
          s_nxt.vec = IEXU_VEC_ADDR_ERR;
          s_nxt.st = IEXU_ST_PUSH_SR;
        end
      end
      default: s_nxt.st = IEXU_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_r <= '{st: IEXU_ST_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_busy = s_r.st != IEXU_ST_IDLE;
  assign o_irq_ack = s_r.irq_ack;
  assign o_pc_load = s_r.pc_load;
  assign o_program_counter = s_r.pc;
  assign o_stack_pointer = s_r.sp;
endmodule

// ===== tb/iexu_sva.sv
/*
  Checker on the exception unit top ports.
  Assumes a bind onto iexu_top.
*/
module iexu_sva
  import iexu_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [31:0] i_status_word,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  input wire logic o_mem_req,
  input wire logic o_mem_wr,
  input wire logic [31:0] o_mem_addr,
  input wire logic [31:0] o_mem_wdata,
  input wire logic o_pc_load,
  input wire logic o_irq_ack,
  input wire logic [31:0] o_program_counter
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] wr_cnt_r;
  logic [31:0] wa_r;
  logic [31:0] hv_r;
  wire wr_ok = o_mem_req && o_mem_wr && i_mem_ack;
  wire rd_ok = o_mem_req && !o_mem_wr && i_mem_ack;
  // Counts pushes acked since the last handler load.
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_cnt_r <= 2'h0;
      wa_r <= 32'h0;
      hv_r <= 32'h0;
    end else begin
      if (o_pc_load) begin
        wr_cnt_r <= 2'h0;
      end else if (wr_ok) begin
        wr_cnt_r <= wr_cnt_r + 2'h1;
      end
      if (wr_ok) begin
        wa_r <= o_mem_addr;
      end
      if (rd_ok) begin
        hv_r <= i_mem_rdata;
      end
    end
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);
  property p_sr_first;
    o_mem_req && o_mem_wr && wr_cnt_r == 2'h0 && o_mem_addr[1:0] == 2'h0 |-> o_mem_wdata == i_status_word;
  endproperty
  a_sr_first: assert property (p_sr_first) else $error("first push not status");
  property p_sp_step;
    o_mem_req && o_mem_wr && wr_cnt_r == 2'h1 |-> o_mem_addr == wa_r - 32'h4;
  endproperty
  a_sp_step: assert property (p_sp_step) else $error("bad push step");
  property p_hold;
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_wr);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_read_after;
    o_mem_req && !o_mem_wr |-> wr_cnt_r == 2'h2;
  endproperty
  a_read_after: assert property (p_read_after) else $error("vector read early");
  property p_load_after;
    rd_ok |-> ##[1:2] o_pc_load;
  endproperty
  a_load_after: assert property (p_load_after) else $error("no handler load");
  property p_load_val;
    o_pc_load |-> o_program_counter == hv_r;
  endproperty
  a_load_val: assert property (p_load_val) else $error("bad handler");
  property p_pulse;
    o_pc_load |=> !o_pc_load;
  endproperty
  a_pulse: assert property (p_pulse) else $error("load too long");
  property p_two;
    o_pc_load |-> wr_cnt_r == 2'h2;
  endproperty
  a_two: assert property (p_two) else $error("push count");
  property p_irq_stack;
    o_irq_ack |=> o_mem_req && o_mem_wr;
  endproperty
  a_irq_stack: assert property (p_irq_stack) else $error("interrupt entry not stacking");
  c_entry: cover property (o_pc_load);
  c_slow: cover property (o_mem_req && !i_mem_ack ##1 o_mem_req);
  c_nest: cover property (o_pc_load ##[1:20] o_pc_load);
endmodule
bind iexu_top iexu_sva sva_u (.i_clk_sys, .i_rst_b, .i_status_word, .i_mem_ack, .i_mem_rdata, .o_mem_req,
  .o_mem_wr, .o_mem_addr, .o_mem_wdata, .o_pc_load, .o_irq_ack, .o_program_counter);

// ===== tb/iexu_mem_model.sv
/*
  Memory partner holding stack writes; a read returns its address XOR 5a5a_0000.
  Assumes one request at a time, held until acked.
*/
module iexu_mem_model (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_clr,
  input wire logic i_slow,
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] wa [8];
  logic [31:0] wd [8];
  int n;
  int w;
  // Read data is only valid with ack; otherwise it toggles.
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      n <= 0;
      w <= 0;
      o_ack <= 1'b0;
      o_rdata <= 32'h0;
    end else begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_clr) begin
        n <= 0;
      end
      if (i_req && !o_ack) begin
        if (i_slow && w < 2) begin
          w <= w + 1;
        end else begin
          w <= 0;
          o_ack <= 1'b1;
          if (i_wr) begin
            wa[n[2:0]] <= i_addr;
            wd[n[2:0]] <= i_wdata;
            n <= n + 1;
          end else begin
            o_rdata <= i_addr ^ 32'h5a5a_0000;
          end
        end
      end
    end
  end
endmodule

// ===== tb/testbench.sv
/*
  Self-checking bench for the exception unit.
  Assumes the checker and memory model are compiled first.
*/
module testbench
  import iexu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk_sys, i_rst_b, i_dec_valid, i_addr_err, i_irq_req, i_mem_ack, clr, slow;
  logic [15:0] i_dec_op;
  logic [7:0] i_irq_vec;
  logic [31:0] i_dec_pc, i_branch_target, i_status_word, i_stack_pointer, i_vector_table_base, i_mem_rdata;
  logic o_mem_req, o_mem_wr, o_busy, o_irq_ack, o_pc_load;
  logic [31:0] o_mem_addr, o_mem_wdata, o_program_counter, o_stack_pointer;
  int errors, n_checks;
  iexu_top dut_u (.i_clk_sys, .i_rst_b, .i_dec_valid, .i_dec_op, .i_dec_pc, .i_branch_target, .i_status_word,
    .i_stack_pointer, .i_vector_table_base, .i_addr_err, .i_irq_req, .i_irq_vec, .o_mem_req, .o_mem_wr,
    .o_mem_addr, .o_mem_wdata, .i_mem_ack, .i_mem_rdata, .o_busy, .o_irq_ack, .o_pc_load,
    .o_program_counter, .o_stack_pointer);
  iexu_mem_model mem_u (.i_clk_sys, .i_rst_b, .i_clr(clr), .i_slow(slow), .i_req(o_mem_req),
    .i_wr(o_mem_wr), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic logic [31:0] hv(input logic [7:0] v);
    return (i_vector_table_base + {22'h0, v, 2'h0}) ^ 32'h5a5a_0000;
  endfunction
  task automatic dec(input logic [15:0] op, input logic [31:0] pc);
    @(negedge i_clk_sys);
    i_dec_valid = 1'b1;
    i_dec_op = op;
    i_dec_pc = pc;
    clr = 1'b1;
    @(negedge i_clk_sys);
    i_dec_valid = 1'b0;
    clr = 1'b0;
  endtask
  task automatic wl;
    int k;
    k = 0;
    while (o_pc_load !== 1'b1 && k < 200) begin
      @(negedge i_clk_sys);
      k++;
    end
    chk({31'h0, o_pc_load}, 32'h1);
  endtask
  task automatic run(input logic [15:0] op, input logic [31:0] pc, input logic [31:0] ret, input logic [7:0] v);
    dec(op, pc);
    wl;
    chk(mem_u.wa[0], i_stack_pointer - 32'h4);
    chk(mem_u.wd[1], ret);
    chk(o_stack_pointer, i_stack_pointer - 32'h8);
    chk(o_program_counter, hv(v));
  endtask
  task automatic t_trap;
    for (int i = 0; i < 2; i++) begin
      slow = i[0];
      run({8'hc3, 8'(i * 255)}, 32'h0000_0100, 32'h0000_0102, 8'(i * 255));
    end
    slow = 1'b0;
  endtask
  task automatic t_slot;
    logic [15:0] br [10] = '{16'h412b, 16'h410b, 16'h0123, 16'h0103, 16'h000b, 16'h002b, 16'ha010, 16'hb010,
      16'h8f10, 16'h8d10};
    logic [15:0] sl [5] = '{16'hfff0, 16'h8900, 16'h8b00, 16'hc320, 16'ha010};
    for (int i = 0; i < 10; i++) begin
      dec(br[i], 32'h0000_0200);
      run(sl[i % 5], 32'h0000_0202, i_branch_target, IEXU_VEC_ILL_SLOT);
    end
  endtask
  task automatic t_gen;
    run(16'hfff5, 32'h0000_0300, 32'h0000_0300, IEXU_VEC_ILL_GEN);
  endtask
  task automatic t_hold;
    dec(16'ha010, 32'h0000_0400);
    i_addr_err = 1'b1;
    @(negedge i_clk_sys);
    i_addr_err = 1'b0;
    i_irq_req = 1'b1;
    dec(16'h0009, 32'h0000_0402);
    i_irq_req = 1'b0;
    @(negedge i_clk_sys);
    chk({31'h0, o_busy}, 32'h0);
    run(16'h0009, i_branch_target, i_branch_target, IEXU_VEC_ADDR_ERR);
    run(16'h0009, i_branch_target, i_branch_target, i_irq_vec);
  endtask
  task automatic t_dis;
    logic [15:0] ds [8] = '{16'h400e, 16'h4007, 16'h0002, 16'h4003, 16'h400a, 16'h4006, 16'h000a, 16'h4002};
    for (int i = 0; i < 8; i++) begin
      dec(ds[i], 32'h0000_0500);
      i_irq_req = 1'b1;
      dec(16'h0009, 32'h0000_0502);
      i_irq_req = 1'b0;
      @(negedge i_clk_sys);
      chk({31'h0, o_busy}, 32'h0);
      run(16'h0009, 32'h0000_0504, 32'h0000_0504, i_irq_vec);
    end
    dec(16'h4007, 32'h0000_0500);
    i_addr_err = 1'b1;
    @(negedge i_clk_sys);
    i_addr_err = 1'b0;
    run(16'h0009, 32'h0000_0502, 32'h0000_0502, IEXU_VEC_ADDR_ERR);
  endtask
  task automatic t_mis;
    logic [31:0] h;
    i_stack_pointer = 32'h0000_0f02;
    dec(16'hc310, 32'h0000_0600);
    wl;
    h = o_program_counter;
    chk(h, hv(8'h10));
    @(negedge i_clk_sys);
    wl;
    chk(mem_u.wa[1], 32'h0000_0efa);
    chk(mem_u.wa[2], 32'h0000_0ef6);
    chk(mem_u.wd[3], h);
    chk(o_program_counter, hv(IEXU_VEC_ADDR_ERR));
    chk(o_stack_pointer, 32'h0000_0ef2);
    repeat (40) @(negedge i_clk_sys);
    chk(mem_u.n, 32'h4);
    i_stack_pointer = 32'h0000_1000;
  endtask
  initial begin
    i_rst_b = 1'b0;
    i_dec_valid = 1'b0;
    i_dec_op = 16'h0009;
    i_dec_pc = 32'h0;
    i_addr_err = 1'b0;
    i_irq_req = 1'b0;
    i_irq_vec = 8'h40;
    clr = 1'b0;
    slow = 1'b0;
    i_branch_target = 32'h0000_2000;
    i_status_word = 32'h0000_00f0;
    i_stack_pointer = 32'h0000_1000;
    i_vector_table_base = 32'h0000_0400;
    repeat (4) @(negedge i_clk_sys);
    i_rst_b = 1'b1;
    t_trap;
    t_slot;
    t_gen;
    t_hold;
    t_dis;
    t_mis;
    give_verdict;
  end
  initial begin
    #50000;
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict;
  end
endmodule
